// ===== hdl/kte_ctrl.sv
// Top of the keyless entry, theft deterrent and panic alarm controller.
// Assumes radio messages arrive as a code plus kind with a one-cycle strobe on clk_sys;
// door, lock, ignition and tool inputs are raw pins and are synchronised here.
`timescale 1ns/100ps

module kte_ctrl (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic msg_valid,
  input wire logic [1:0] msg_kind,
  input wire logic [23:0] msg_code,
  input wire logic door_open_in,
  input wire logic doors_locked_in,
  input wire logic doors_unlocked_in,
  input wire logic key_in_in,
  input wire logic engine_run_in,
  input wire logic lamp_door_sel_in,
  input wire logic tool_learn_in,
  input wire logic tool_clear_in,
  input wire logic stored_armed,
  output logic lock_relay,
  output logic unlock_relay,
  output logic horn,
  output logic hazard,
  output logic room_lamp,
  output logic learning,
  output logic armed_state
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for all pin inputs.
  logic [8:0] sync1;
  logic [8:0] sync2;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {door_open_in, doors_locked_in, doors_unlocked_in, key_in_in, engine_run_in,
                lamp_door_sel_in, tool_learn_in, tool_clear_in, stored_armed};
      sync2 <= sync1;
    end
  end

  logic door_open;
  logic doors_locked;
  logic doors_unlocked;
  logic key_in;
  logic engine_run;
  logic lamp_sel;
  logic tool_learn;
  logic tool_clear;
  logic armed_strap;
  assign {door_open, doors_locked, doors_unlocked, key_in, engine_run, lamp_sel, tool_learn,
          tool_clear, armed_strap} = sync2;

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler producing one tick per tick period.
  typedef struct packed {
    logic [21:0] pre;
    logic tick;
    kte_pkg::kte_mode_t mode;
    logic panic;
    logic powerup;
    logic [1:0] boot_cnt;
    logic door_prev;
    logic [1:0] blinks_left;
    logic alarm_phase;
    logic lock_relay;
    logic unlock_relay;
    logic horn;
    logic hazard;
    logic room_lamp;
    logic learning;
    logic armed_state;
  } kte_top_t;

  kte_top_t r;
  kte_top_t next_r;

  // Decoded events.
  logic known;
  logic [2:0] code_count;
  logic ok_msg;
  logic m_lock;
  logic m_unlock;
  logic m_panic;
  logic learn_now;
  logic registering;

  // Learning only with the key out and the tool asking for it.
  assign registering = tool_learn && !key_in;
  assign learn_now = registering && msg_valid && msg_kind == kte_pkg::MSG_PANIC;
  assign ok_msg = msg_valid && known && !registering;
  assign m_lock = ok_msg && msg_kind == kte_pkg::MSG_LOCK;
  assign m_unlock = ok_msg && msg_kind == kte_pkg::MSG_UNLOCK;
  assign m_panic = ok_msg && msg_kind == kte_pkg::MSG_PANIC;

  kte_code_store u_store (
    .clk_sys(clk_sys),
    .srst(srst),
    .learn(learn_now),
    .clear(tool_clear && registering),
    .code(msg_code),
    .known(known),
    .count(code_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Timers for the timed outputs (three for the horn) and one for the relock, all driven by the same tick.
  logic trig;
  logic panic_start;
  logic alarm_start;
  logic alarm_stop;
  logic relock_start;
  logic half_start;
  logic blink_start;
  logic panic_busy;
  logic panic_done;
  logic alarm_busy;
  logic alarm_done;
  logic relock_busy;
  logic relock_done;
  logic lamp_busy;
  logic unl_busy;
  logic lockp_busy;
  logic half_done;
  logic blink_busy;
  logic blink_done;

  // The panic timer follows the next panic flag, so its stop never beats the start cycle.
  kte_timer u_panic (.clk_sys(clk_sys), .srst(srst), .tick(r.tick), .start(panic_start),
    .stop(!next_r.panic), .load(kte_pkg::PANIC_TICKS),
    .busy(panic_busy), .done(panic_done));
  kte_timer u_alarm (.clk_sys(clk_sys), .srst(srst), .tick(r.tick), .start(alarm_start),
    .stop(alarm_stop), .load(kte_pkg::ALARM_TICKS), .busy(alarm_busy), .done(alarm_done));
  kte_timer u_half (.clk_sys(clk_sys), .srst(srst), .tick(r.tick), .start(half_start),
    .stop(1'b0), .load(kte_pkg::ALARM_HALF_TICKS), .busy(), .done(half_done));
  kte_timer u_relock (.clk_sys(clk_sys), .srst(srst), .tick(r.tick), .start(m_unlock),
    .stop(door_open || key_in || m_lock), .load(kte_pkg::RELOCK_TICKS),
    .busy(relock_busy), .done(relock_done));
  kte_timer u_lamp (.clk_sys(clk_sys), .srst(srst), .tick(r.tick), .start(m_unlock && lamp_sel),
    .stop(m_lock), .load(kte_pkg::LAMP_TICKS), .busy(lamp_busy), .done());
  // A newer remote command ends the opposite relay pulse; otherwise lock would mask a later unlock.
  kte_timer u_unl (.clk_sys(clk_sys), .srst(srst), .tick(r.tick), .start(m_unlock),
    .stop(m_lock || relock_start), .load(kte_pkg::UNLOCK_TICKS), .busy(unl_busy), .done());
  kte_timer u_lockp (.clk_sys(clk_sys), .srst(srst), .tick(r.tick), .start(m_lock || relock_start),
    .stop(m_unlock), .load(kte_pkg::LOCK_TICKS), .busy(lockp_busy), .done());
  kte_timer u_blink (.clk_sys(clk_sys), .srst(srst), .tick(r.tick), .start(blink_start),
    .stop(1'b0), .load(kte_pkg::BLINK_TICKS), .busy(blink_busy), .done(blink_done));

  ////////////////////////////////////////////////////////////////////////////
  // Theft trigger: a door opening edge while armed or after a finished warning.
  // An edge, so a door left open after the warning does not restart the alarm at once.
  assign trig = door_open && !r.door_prev &&
                (r.mode == kte_pkg::KTE_ARMED || r.mode == kte_pkg::KTE_WARN_DONE);
  assign relock_start = relock_done && !door_open && !key_in;
  assign alarm_start = trig || r.powerup;
  assign alarm_stop = m_lock || m_unlock || m_panic || (r.mode != kte_pkg::KTE_WARNING && !alarm_start);
  assign panic_start = m_panic && !r.panic;
  assign half_start = alarm_start || (half_done && r.mode == kte_pkg::KTE_WARNING);
  assign blink_start = (r.blinks_left != 2'h0 && !blink_busy) || (blink_done && r.blinks_left > 2'h1);

  // Main state, panic, blink and output logic.
  always_comb begin
    next_r = r;
    next_r.powerup = 1'b0;
    next_r.door_prev = door_open;
    // The stored state is taken once the second synchroniser stage holds it.
    if (r.boot_cnt <= kte_pkg::BOOT_SAMPLE) begin
      next_r.boot_cnt = r.boot_cnt + 2'h1;
    end
    if (r.boot_cnt == kte_pkg::BOOT_SAMPLE) begin
      next_r.powerup = armed_strap;
    end
    // Prescaler for the shared tick.
    if (r.pre == 22'(kte_pkg::TICK_CYCLES - 1)) begin
      next_r.pre = 22'h000000;
      next_r.tick = 1'b1;
    end else begin
      next_r.pre = r.pre + 22'h000001;
      next_r.tick = 1'b0;
    end
    // Blink phases count down; odd counts are lit, so three gives two flashes with a gap.
    if (blink_done && r.blinks_left != 2'h0) begin
      next_r.blinks_left = r.blinks_left - 2'h1;
    end
    case (r.mode)
      kte_pkg::KTE_NORMAL, kte_pkg::KTE_ARMED_READY, kte_pkg::KTE_RELOCK_READY: begin
        if (m_lock) begin
          if (!door_open && doors_locked) begin
            next_r.mode = kte_pkg::KTE_ARMED;
            next_r.blinks_left = 2'h3;
          end else begin
            next_r.mode = kte_pkg::KTE_ARMED_READY;
          end
        end else if (r.mode == kte_pkg::KTE_ARMED_READY && (key_in || !doors_locked)) begin
          next_r.mode = kte_pkg::KTE_NORMAL;
        end else if (m_unlock) begin
          next_r.mode = kte_pkg::KTE_RELOCK_READY;
        end else if (relock_start) begin
          next_r.mode = kte_pkg::KTE_ARMED;
          next_r.blinks_left = 2'h3;
        end else if (r.mode == kte_pkg::KTE_RELOCK_READY && !relock_busy) begin
          next_r.mode = kte_pkg::KTE_NORMAL;
        end
      end
      kte_pkg::KTE_ARMED, kte_pkg::KTE_WARN_DONE: begin
        if (m_unlock || engine_run) begin
          next_r.mode = kte_pkg::KTE_NORMAL;
        end else if (trig) begin
          next_r.mode = kte_pkg::KTE_WARNING;
        end else if (m_lock) begin
          next_r.mode = kte_pkg::KTE_ARMED;
          next_r.blinks_left = 2'h3;
        end
      end
      kte_pkg::KTE_WARNING: begin
        if (m_unlock || engine_run) begin
          next_r.mode = kte_pkg::KTE_NORMAL;
        end else if (m_lock || m_panic || alarm_done || key_in) begin
          next_r.mode = kte_pkg::KTE_WARN_DONE;
        end
      end
      default: begin
        next_r.mode = kte_pkg::KTE_NORMAL;
      end
    endcase
    // A power-up restore while armed behaves as a trigger in armed mode.
    if (r.powerup) begin
      next_r.mode = kte_pkg::KTE_WARNING;
    end
    if (m_unlock && doors_unlocked) begin
      next_r.blinks_left = 2'h1;
    end
    // Panic runs alongside the theft state; it leaves armed modes untouched, but a panic message ends a warning.
    if (panic_start) begin
      next_r.panic = 1'b1;
    end else if (m_lock || m_unlock || m_panic || panic_done || trig) begin
      next_r.panic = 1'b0;
    end
    if (alarm_start) begin
      next_r.alarm_phase = 1'b1;
    end else if (half_done) begin
      next_r.alarm_phase = !r.alarm_phase;
    end
    next_r.lock_relay = lockp_busy;
    next_r.unlock_relay = unl_busy && !lockp_busy;
    next_r.horn = (r.mode == kte_pkg::KTE_WARNING && alarm_busy && r.alarm_phase) || r.panic;
    next_r.hazard = next_r.horn || (blink_busy && r.blinks_left[0]);
    next_r.room_lamp = lamp_busy && !m_lock;
    next_r.learning = registering;
    next_r.armed_state = (r.mode == kte_pkg::KTE_ARMED);
  end

  // The controller state record r registers here; reset leaves it normal, unarmed and silent.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign lock_relay = r.lock_relay;
  assign unlock_relay = r.unlock_relay;
  assign horn = r.horn;
  assign hazard = r.hazard;
  assign room_lamp = r.room_lamp;
  assign learning = r.learning;
  assign armed_state = r.armed_state;

  ////////////////////////////////////////////////////////////////////////////
  // Checks beside the logic.
  sequence s_panic_req;
    m_panic && !r.panic && !registering;
  endsequence

  AST_PANIC_ON: assert property (@(posedge clk_sys) disable iff (srst)
    s_panic_req |=> ##1 horn) else $error("panic did not sound horn");
  AST_PANIC_OFF: assert property (@(posedge clk_sys) disable iff (srst)
    (r.panic && m_unlock) |=> !r.panic) else $error("panic not cancelled");
  AST_WARN_STOP: assert property (@(posedge clk_sys) disable iff (srst)
    (r.mode == kte_pkg::KTE_WARNING && m_panic && !engine_run) |=> r.mode == kte_pkg::KTE_WARN_DONE)
    else $error("warning not stopped by panic");
  AST_TRIG_SWAP: assert property (@(posedge clk_sys) disable iff (srst)
    (r.panic && trig && !m_unlock && !engine_run) |=> (!r.panic && r.mode == kte_pkg::KTE_WARNING))
    else $error("trigger did not swap");
  AST_PANIC_KEEP: assert property (@(posedge clk_sys) disable iff (srst)
    (panic_start && r.mode == kte_pkg::KTE_ARMED && !trig && !engine_run) |=> r.mode == kte_pkg::KTE_ARMED)
    else $error("panic changed armed state");
  AST_DOOR_TRIG: assert property (@(posedge clk_sys) disable iff (srst)
    (r.mode == kte_pkg::KTE_ARMED && door_open && !r.door_prev && !m_unlock && !engine_run) |=>
    r.mode == kte_pkg::KTE_WARNING)
    else $error("door open while armed did not alarm");
  AST_CANCEL: assert property (@(posedge clk_sys) disable iff (srst)
    (r.mode == kte_pkg::KTE_ARMED && engine_run && !r.powerup) |=> r.mode == kte_pkg::KTE_NORMAL)
    else $error("engine start did not disarm");
  AST_LOCK_OUT: assert property (@(posedge clk_sys) disable iff (srst)
    m_lock |=> ##1 lock_relay) else $error("lock relay late");
  AST_UNLOCK_OUT: assert property (@(posedge clk_sys) disable iff (srst)
    (m_unlock && !m_lock) |=> ##1 unlock_relay) else $error("unlock relay missing");
  AST_LAMP_OFF: assert property (@(posedge clk_sys) disable iff (srst)
    m_lock |=> !room_lamp) else $error("room lamp stayed on after lock");
  AST_SILENT: assert property (@(posedge clk_sys) disable iff (srst)
    (registering && msg_valid && !r.panic && !lockp_busy && !unl_busy && !relock_done) |=>
    (!r.panic && !lockp_busy && !unl_busy)) else $error("message acted during learning");
  AST_SLOTS: assert property (@(posedge clk_sys) disable iff (srst)
    code_count <= kte_pkg::SLOTS_MAX) else $error("too many codes stored");
  AST_PANIC_TIMED: assert property (@(posedge clk_sys) disable iff (srst)
    r.panic |-> (panic_busy || panic_done)) else $error("panic runs without its timer");

endmodule

// ===== hdl/kte_pkg.sv
// Constants, timing figures and state types of the keyless entry and theft alarm controller.
// Assumes a single 200 MHz system clock; every duration is built from the shared tick.
//
// Overview of operation
// - Panic message sounds horn and flasher 27 s.
// - Any button message stops running panic alarm.
// - Panic message stops a sounding theft alarm.
// - Theft trigger during panic swaps to theft alarm.
// - Panic in armed-type states keeps theft state.
// - Battery restored while armed starts theft alarm.
// - Unlock, no door opened 30 s: relock, arm.
// - Lock command locks doors, activates theft mode.
// - Five codes max, register only keyless, tool.
// - Registration suppresses outputs from received codes.
// - Registration learns codes from panic messages only.
// - Lock output at once; closed, locked: arm, blink twice.
// - Remote unlock energises unlock relay 0.5 s.
// - Blink hazard once only if all doors unlocked.
// - Unlock lights lamp 30 s; lock ends it.
// - Theft alarm pulses 1 s for 27 s.
// - Door opened while armed triggers theft alarm.
// - Remote unlock or engine start cancels armed.

package kte_pkg;

  // Clock and tick.
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // Cycles after reset release until the second synchroniser stage holds the pins.
  localparam logic [1:0] BOOT_SAMPLE = 2'h2;

  // Durations in their own units, then in ticks.
  localparam int PANIC_S = 27;
  localparam int ALARM_S = 27;
  localparam int ALARM_PERIOD_MS = 1000;
  localparam int RELOCK_S = 30;
  localparam int LAMP_S = 30;
  localparam int UNLOCK_MS = 500;
  localparam int BLINK_MS = 500;
  localparam int LOCK_PULSE_MS = 500;

  localparam logic [15:0] PANIC_TICKS = 16'(PANIC_S * 1000 / TICK_MS);
  localparam logic [15:0] ALARM_TICKS = 16'(ALARM_S * 1000 / TICK_MS);
  localparam logic [15:0] ALARM_HALF_TICKS = 16'(ALARM_PERIOD_MS / 2 / TICK_MS);
  localparam logic [15:0] RELOCK_TICKS = 16'(RELOCK_S * 1000 / TICK_MS);
  localparam logic [15:0] LAMP_TICKS = 16'(LAMP_S * 1000 / TICK_MS);
  localparam logic [15:0] UNLOCK_TICKS = 16'(UNLOCK_MS / TICK_MS);
  localparam logic [15:0] BLINK_TICKS = 16'(BLINK_MS / TICK_MS);
  localparam logic [15:0] LOCK_TICKS = 16'(LOCK_PULSE_MS / TICK_MS);

  // Code store.
  localparam int CODE_W = 24;
  localparam int CODE_SLOTS = 5;
  localparam logic [2:0] SLOTS_MAX = 3'h5;

  // Received message kinds.
  localparam logic [1:0] MSG_LOCK = 2'h0;
  localparam logic [1:0] MSG_UNLOCK = 2'h1;
  localparam logic [1:0] MSG_PANIC = 2'h2;

  // Theft-deterrent states.
  typedef enum logic [2:0] {
    KTE_NORMAL,
    KTE_ARMED_READY,
    KTE_ARMED,
    KTE_WARNING,
    KTE_WARN_DONE,
    KTE_RELOCK_READY
  } kte_mode_t;

endpackage

// ===== hdl/kte_timer.sv
// One down-counter timer driven by the shared tick.
// Assumes tick is a one-cycle pulse from the same clock domain.
`timescale 1ns/100ps

module kte_timer (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [15:0] load,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [15:0] count;
    logic done;
  } kte_tmr_t;

  kte_tmr_t r;
  kte_tmr_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // Start reloads even while running, so a repeated request restarts it.
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (stop) begin
      next_r.count = 16'h0000;
    end else if (start) begin
      next_r.count = load;
    end else if (tick && r.count != 16'h0000) begin
      next_r.count = r.count - 16'h0001;
      next_r.done = (r.count == 16'h0001);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign busy = (r.count != 16'h0000);
  assign done = r.done;

endmodule

// ===== hdl/kte_code_store.sv
// Store of learned transmitter codes, with a match lookup.
// Assumes codes arrive with a one-cycle valid strobe from the same clock.
`timescale 1ns/100ps

module kte_code_store (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic learn,
  input wire logic clear,
  input wire logic [23:0] code,
  output logic known,
  output logic [2:0] count
);

  typedef struct packed {
    logic [kte_pkg::CODE_SLOTS-1:0][kte_pkg::CODE_W-1:0] slot;
    logic [2:0] count;
  } kte_store_t;

  kte_store_t r;
  kte_store_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // Learning stops at the last slot; a duplicate code is not stored twice.
  always_comb begin
    next_r = r;
    if (clear) begin
      next_r.count = 3'h0;
    end else if (learn && !known && r.count < kte_pkg::SLOTS_MAX) begin
      next_r.slot[r.count] = code;
      next_r.count = r.count + 3'h1;
    end
  end

  always_comb begin
    known = 1'b0;
    for (int i = 0; i < kte_pkg::CODE_SLOTS; i++) begin
      if (3'(i) < r.count && r.slot[i] == code) begin
        known = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign count = r.count;

endmodule

// ===== verification/kte_remote.sv
// Behavioural model of the handheld transmitter and its radio receiver.
// Assumes the controller samples msg_valid on rising clk_sys edges; the bench calls press().
`timescale 1ns/100ps

module kte_remote (
  input wire logic clk_sys,
  output logic msg_valid,
  output logic [1:0] msg_kind,
  output logic [23:0] msg_code,
  output logic [1:0] led_blinks
);

  ////////////////////////////////////////////////////////////////////////////
  // Idle line levels; the kind is a value the controller never acts on.
  initial begin
    msg_valid = 1'b0;
    msg_kind = 2'h3;
    msg_code = 24'h000000;
    led_blinks = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One button press becomes at most one message, a single-cycle strobe set at a falling edge.
  // A hold between the short and long limits sends nothing, as on the real key.
  task automatic press(input logic lock_btn, input int hold_ms, input logic [23:0] code);
    logic send;
    logic [1:0] kind;
    send = 1'b1;
    kind = kte_pkg::MSG_LOCK;
    if (!lock_btn && hold_ms > 2000) begin
      kind = kte_pkg::MSG_PANIC;
    end else if (hold_ms < 500) begin
      kind = lock_btn ? kte_pkg::MSG_LOCK : kte_pkg::MSG_UNLOCK;
    end else begin
      send = 1'b0;
    end
    led_blinks = (hold_ms > 2000) ? 2'h2 : 2'h1;
    @(negedge clk_sys);
    msg_valid = send;
    msg_kind = kind;
    msg_code = code;
    @(negedge clk_sys);
    // The qualifiers stop showing the last message once the strobe drops.
    msg_valid = 1'b0;
    msg_kind = ~msg_kind;
    msg_code = ~msg_code;
  endtask

endmodule

// ===== verification/kte_ctrl_bench.sv
// Self-checking bench for the keyless entry and theft alarm controller.
// Assumes the real 10 ms tick, so timed outputs are judged at onset and over short holds only.
`timescale 1ns/100ps

module kte_ctrl_bench;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic door_open_in = 1'b0;
  logic doors_locked_in = 1'b0;
  logic doors_unlocked_in = 1'b1;
  logic key_in_in = 1'b0;
  logic engine_run_in = 1'b0;
  logic lamp_door_sel_in = 1'b1;
  logic tool_learn_in = 1'b0;
  logic tool_clear_in = 1'b0;
  logic stored_armed = 1'b0;
  logic msg_valid;
  logic [1:0] msg_kind;
  logic [23:0] msg_code;
  logic [1:0] led_blinks;
  logic [6:0] outs;
  int err_total = 0;
  int comparisons = 0;
  localparam int O_LOCK = 0, O_UNL = 1, O_HORN = 2, O_HAZ = 3, O_LAMP = 4, O_LRN = 5, O_ARM = 6;
  localparam logic [23:0] C_BASE = 24'h5a0010;
  localparam logic [23:0] C_BAD = 24'h3c0f00;

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz, device under test and transmitter model.
  always #2.5 clk_sys = ~clk_sys;

  kte_remote u_key (
    .clk_sys(clk_sys),
    .msg_valid(msg_valid),
    .msg_kind(msg_kind),
    .msg_code(msg_code),
    .led_blinks(led_blinks)
  );

  kte_ctrl u_dut (
    .clk_sys(clk_sys),
    .srst(srst),
    .msg_valid(msg_valid),
    .msg_kind(msg_kind),
    .msg_code(msg_code),
    .door_open_in(door_open_in),
    .doors_locked_in(doors_locked_in),
    .doors_unlocked_in(doors_unlocked_in),
    .key_in_in(key_in_in),
    .engine_run_in(engine_run_in),
    .lamp_door_sel_in(lamp_door_sel_in),
    .tool_learn_in(tool_learn_in),
    .tool_clear_in(tool_clear_in),
    .stored_armed(stored_armed),
    .lock_relay(outs[0]),
    .unlock_relay(outs[1]),
    .horn(outs[2]),
    .hazard(outs[3]),
    .room_lamp(outs[4]),
    .learning(outs[5]),
    .armed_state(outs[6])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers; everything samples and drives at falling edges so nothing races the clock.
  task automatic check(input string name, input logic exp, input logic seen);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %b, seen %b", name, exp, seen);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Bounded wait for an output to settle at a value; the wait itself is the only slack allowed.
  task automatic wait_is(input int idx, input logic val, input int limit, input string name);
    int n;
    n = 0;
    while (outs[idx] !== val && n < limit) begin
      @(negedge clk_sys);
      n++;
    end
    check(name, val, outs[idx]);
  endtask

  task automatic close_out;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  // Learning needs the key out; lock messages teach nothing and a sixth code is dropped.
  task automatic t_learn;
    key_in_in = 1'b1;
    tool_learn_in = 1'b1;
    wait_n(6);
    check("learning with key in", 1'b0, outs[O_LRN]);
    key_in_in = 1'b0;
    wait_n(6);
    check("learning", 1'b1, outs[O_LRN]);
    u_key.press(1'b1, 100, C_BAD);
    for (int i = 0; i < 6; i++) begin
      u_key.press(1'b0, 2500, C_BASE + 24'(i));
    end
    wait_n(3);
    check("outputs while learning", 1'b0, |outs[O_LAMP:O_LOCK]);
    tool_learn_in = 1'b0;
    wait_n(6);
    check("learning ended", 1'b0, outs[O_LRN]);
  endtask

  // Codes that were refused at learning must not move a relay.
  task automatic t_reject;
    u_key.press(1'b1, 100, C_BASE + 24'h5);
    wait_n(2);
    check("lock relay sixth code", 1'b0, outs[O_LOCK]);
    u_key.press(1'b1, 100, C_BAD);
    wait_n(2);
    check("lock relay lock-learned code", 1'b0, outs[O_LOCK]);
  endtask

  // Unlock from normal, then a lock that kills the lamp and arms with doors closed and locked.
  task automatic t_unlock_lock;
    u_key.press(1'b0, 100, C_BASE);
    wait_n(2);
    check("unlock relay", 1'b1, outs[O_UNL]);
    wait_is(O_LAMP, 1'b1, 4, "room lamp");
    wait_is(O_HAZ, 1'b1, 4, "hazard unlock blink");
    wait_n(200);
    check("unlock relay held", 1'b1, outs[O_UNL]);
    doors_unlocked_in = 1'b0;
    doors_locked_in = 1'b1;
    wait_n(4);
    u_key.press(1'b1, 100, C_BASE + 24'h1);
    wait_n(2);
    check("lock relay", 1'b1, outs[O_LOCK]);
    wait_is(O_LAMP, 1'b0, 3, "room lamp off by lock");
    wait_is(O_ARM, 1'b1, 8, "armed after lock");
  endtask

  // Panic while armed keeps the mode; a lock press then silences it.
  task automatic t_panic;
    u_key.press(1'b0, 2500, C_BASE + 24'h2);
    wait_n(2);
    check("panic horn", 1'b1, outs[O_HORN]);
    check("led blinks on hold", 1'b1, led_blinks == 2'h2);
    wait_n(200);
    check("panic horn held", 1'b1, outs[O_HORN]);
    check("armed kept in panic", 1'b1, outs[O_ARM]);
    u_key.press(1'b1, 100, C_BASE + 24'h3);
    wait_is(O_HORN, 1'b0, 3, "panic horn cancelled");
  endtask

  // A door opened during a panic while armed swaps to the theft alarm; a panic then stops the warning,
  // and a remote unlock silences the new panic and leaves the controller disarmed.
  task automatic t_theft;
    u_key.press(1'b0, 2500, C_BASE + 24'h2);
    wait_is(O_HORN, 1'b1, 3, "panic horn before trigger");
    door_open_in = 1'b1;
    wait_is(O_ARM, 1'b0, 8, "armed left by door");
    wait_n(200);
    check("theft horn held", 1'b1, outs[O_HORN]);
    door_open_in = 1'b0;
    u_key.press(1'b0, 2500, C_BASE + 24'h1);
    wait_n(2);
    check("panic horn over warning", 1'b1, outs[O_HORN]);
    u_key.press(1'b0, 100, C_BASE + 24'h4);
    wait_is(O_HORN, 1'b0, 3, "horn cancelled by unlock");
    wait_is(O_ARM, 1'b0, 3, "disarmed by unlock");
  endtask

  // Engine start disarms.
  task automatic t_engine;
    u_key.press(1'b1, 100, C_BASE);
    wait_is(O_ARM, 1'b1, 8, "armed again");
    engine_run_in = 1'b1;
    wait_is(O_ARM, 1'b0, 8, "disarmed by engine");
    engine_run_in = 1'b0;
  endtask

  // Second reset with the stored state armed, as when the battery is refitted.
  task automatic t_powerup;
    stored_armed = 1'b1;
    srst = 1'b1;
    wait_n(4);
    check("horn in reset", 1'b0, outs[O_HORN]);
    srst = 1'b0;
    wait_is(O_HORN, 1'b1, 20, "power-up alarm horn");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog; both end through close_out.
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    wait_n(4);
    t_learn();
    t_reject();
    t_unlock_lock();
    t_panic();
    t_theft();
    t_engine();
    t_powerup();
    close_out();
  end

  // The scenarios need under 800 cycles; the 20,000-cycle limit means a hang.
  initial begin
    #100000;
    err_total++;
    $display("unexpected watchdog: expected end of tests, seen timeout");
    close_out();
  end

endmodule
